// file: shared/ars_pkg.sv
// Package for the accumulator register shifter: widths, field positions,
// command encoding and the packed structs for the fan-out groups.
// Assumes a single clock domain driven by the control sequencer.
package ars_pkg;

    localparam int unsigned ARS_W        = 32;
    localparam int unsigned ARS_DBL_W    = 64;
    localparam int unsigned ARS_DIGIT    = 4;
    // Bit numbering follows the convention that bit 00 is the MSB
    localparam int unsigned ARS_BYTE_W   = 8;
    localparam int unsigned ARS_CC_HI    = 2;
    localparam int unsigned ARS_CC_LO    = 3;
    localparam int unsigned ARS_PM_HI    = 4;
    localparam int unsigned ARS_PM_LO    = 7;
    localparam int unsigned ARS_SAR_HI   = 8;
    localparam int unsigned ARS_SAR_CMP  = 14;
    localparam int unsigned ARS_SAR_LO   = 31;
    localparam int unsigned ARS_MS_HI    = 12;
    localparam int unsigned ARS_MS_LO    = 15;
    localparam int unsigned ARS_CHD_HI   = 21;
    localparam int unsigned ARS_CHD_LO   = 23;
    localparam int unsigned ARS_CHA_HI   = 24;
    localparam int unsigned ARS_CHA_LO   = 31;
    localparam int unsigned ARS_SC_HI    = 26;
    localparam int unsigned ARS_SC_LO    = 31;
    localparam int unsigned ARS_PAR_HI   = 30;
    localparam int unsigned ARS_PAR_LO   = 31;
    localparam int unsigned ARS_SIGN     = 0;
    localparam int unsigned ARS_OVF_B    = 1;

    localparam logic [ARS_W-1:0] ARS_ZERO = 32'h0000_0000;
    localparam logic [ARS_W-1:0] ARS_ONES = 32'hFFFF_FFFF;
    localparam logic [ARS_W-1:0] ARS_BYTE0_KEEP = 32'h00FF_FFFF;

    // One command per cycle; the sequencer presents an encoded code
    typedef enum logic [3:0] {
        ARS_CMD_NONE,
        ARS_CMD_RESET_ALL,
        ARS_CMD_RESET_BYTE0,
        ARS_CMD_SET_ONES,
        ARS_CMD_ENTRY,
        ARS_CMD_ADD_RESULT,
        ARS_CMD_INTERCHANGE,
        ARS_CMD_COPY_TO_EXT,
        ARS_CMD_SHR1,
        ARS_CMD_SHL1,
        ARS_CMD_SHR4,
        ARS_CMD_SHL4
    } ars_cmd_e;

    // Fields fanned out to status, channel and shift logic
    typedef struct packed {
        logic [1:0] cond_code;
        logic [3:0] prog_mask;
        logic       prog_mask_zero;
        logic [7:0] sys_mask;
        logic [3:0] machine_state;
        logic [2:0] chan_decode;
        logic [7:0] chan_addr;
        logic [5:0] shift_count;
        logic [1:0] shift_ovf_bits;
        logic       sign;
        logic [1:0] ext_parallel;
    } ars_fanout_s;

    // Second storage address register feed
    typedef struct packed {
        logic [23:0] addr;
        logic        even_odd;
    } ars_addr_s;

endpackage

// file: verification/ars_monitor.sv
// Checker on the accumulator register shifter ports.
// Assumes a bind onto ars_accumulator; one clock, sync reset.
`timescale 1ns/1ps
module ars_monitor
    import ars_pkg::*;
#(
    parameter int unsigned W = ARS_W
)
(
    input wire logic         i_clock,
    input wire logic         i_rst_n,
    input wire logic         i_clk_en,
    input wire ars_cmd_e     i_cmd,
    input wire logic [W-1:0] i_funnel,
    input wire logic         i_decondition,
    input wire logic         i_exp_match,
    input wire logic         i_sign_invert,
    input wire logic [W-1:0] o_acc,
    input wire logic [W-1:0] o_ext,
    input wire logic         o_carry_clear,
    input wire logic         o_acc_zero,
    input wire logic [W-1:0] o_store_data
);
    // Single domain, so one default clock and reset serve all
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    AST_ENTRY: assert property (
        i_clk_en && i_cmd == ARS_CMD_ENTRY && !i_decondition
        |=> o_acc == ($past(o_acc) ^ $past(i_funnel))) else $error("entry");
    AST_DECOND: assert property (
        i_clk_en && i_cmd == ARS_CMD_ENTRY && i_decondition
        |=> $stable(o_acc)) else $error("deconditioned entry changed acc");
    AST_ZERO: assert property (
        o_acc_zero == (o_acc == '0)) else $error("zero flag wrong");
    AST_CLEAR: assert property (
        i_clk_en && i_cmd == ARS_CMD_RESET_ALL
        |=> o_acc == '0 && o_carry_clear) else $error("reset all");
    AST_SET: assert property (
        i_clk_en && i_cmd == ARS_CMD_SET_ONES
        |=> o_acc == ARS_ONES) else $error("set ones");
    AST_SWAP: assert property (
        i_clk_en && i_cmd == ARS_CMD_INTERCHANGE |=> o_acc == $past(o_ext)
        && o_ext == $past(o_acc)) else $error("interchange");
    AST_COPY: assert property (
        i_clk_en && i_cmd == ARS_CMD_COPY_TO_EXT
        |=> o_ext == $past(o_acc) && $stable(o_acc)) else $error("copy");
    AST_ROT4: assert property (
        i_clk_en && i_cmd == ARS_CMD_SHR4 && !i_exp_match
        |=> {o_acc, o_ext} == {$past(o_ext[3:0]), $past(o_acc),
        $past(o_ext[31:4])}) else $error("right four rotate");
    AST_STORE: assert property (
        $past(i_rst_n) && $past(i_clk_en) |-> o_store_data ==
        {$past(o_acc[31]) ^ $past(i_sign_invert), $past(o_acc[30:0])})
        else $error("store sign path");
    // Main scenarios reached
    COV_DEC: cover property (i_cmd == ARS_CMD_ENTRY && i_decondition);
    COV_EXP: cover property (i_cmd == ARS_CMD_SHR4 && i_exp_match);
    COV_BYTE: cover property (i_cmd == ARS_CMD_RESET_BYTE0);
endmodule

// file: verification/ars_seq_model.sv
// Control sequencer model: one command code presented per cycle.
// Assumes the bench calls issue and idle from one process.
`timescale 1ns/1ps
module ars_seq_model
    import ars_pkg::*;
(
    input  wire logic   i_clock,
    output ars_cmd_e    o_cmd,
    output logic [31:0] o_funnel,
    output logic        o_decondition,
    output logic        o_exp_match
);
    // Quiet lines at time zero
    initial
    begin
        o_cmd = ARS_CMD_NONE;
        o_funnel = 32'h0000_0000;
        o_decondition = 1'b0;
        o_exp_match = 1'b0;
    end
    task automatic issue(input ars_cmd_e c, input logic [31:0] d,
                         input logic dc, input logic em);
        @(posedge i_clock);
        o_cmd <= c;
        o_funnel <= d;
        o_decondition <= dc;
        o_exp_match <= em;
    endtask
    // Released funnel shows the inverse so stale data cannot match
    task automatic idle();
        @(posedge i_clock);
        o_cmd <= ARS_CMD_NONE;
        o_funnel <= ~o_funnel;
        o_decondition <= 1'b0;
        o_exp_match <= 1'b0;
    endtask
endmodule

// file: verification/tb_accumulator_register_shifter.sv
// Self-checking bench for the accumulator register shifter.
// Assumes the sequencer model drives command and funnel lines.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_accumulator_register_shifter
    import ars_pkg::*;
;
    logic        i_clock, i_rst_n, i_clk_en, i_subtract, i_sign_invert;
    logic        i_decondition, i_exp_match, o_carry_clear, o_acc_zero;
    logic [31:0] i_funnel, i_adder_a, o_acc, o_ext, o_store_data, m_a, m_e;
    logic [31:0] m_s;
    logic [1:0]  m_p;
    ars_cmd_e    i_cmd;
    ars_fanout_s o_fanout;
    ars_addr_s   o_addr;
    int          n_mismatch, n_compared, cycles;
    ars_seq_model seq (.i_clock(i_clock), .o_cmd(i_cmd), .o_funnel(i_funnel),
        .o_decondition(i_decondition), .o_exp_match(i_exp_match));
    ars_accumulator dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en), .i_cmd(i_cmd), .i_funnel(i_funnel),
        .i_decondition(i_decondition), .i_exp_match(i_exp_match),
        .i_adder_a(i_adder_a), .i_subtract(i_subtract),
        .i_sign_invert(i_sign_invert), .o_acc(o_acc), .o_ext(o_ext),
        .o_carry_clear(o_carry_clear), .o_acc_zero(o_acc_zero),
        .o_store_data(o_store_data), .o_fanout(o_fanout), .o_addr(o_addr));
    // Local model of the coupled pair
    task automatic mdl(input ars_cmd_e c, input logic [31:0] d,
                       input logic dc, input logic em);
        logic [63:0] p;
        p = {m_a, m_e};
        // Parallel positions load on transfers, shift on right moves
        if (c == ARS_CMD_INTERCHANGE || c == ARS_CMD_COPY_TO_EXT)
            m_p = p[33:32];
        if (c == ARS_CMD_SHR1)
            m_p = {p[34], m_p[1]};
        if (c == ARS_CMD_SHR4)
            m_p = p[35:34];
        case (c)
            ARS_CMD_RESET_ALL:   m_a = 32'h0000_0000;
            ARS_CMD_RESET_BYTE0: m_a = m_a & ARS_BYTE0_KEEP;
            ARS_CMD_SET_ONES:    m_a = ARS_ONES;
            ARS_CMD_ENTRY:       m_a = dc ? m_a : m_a ^ d;
            ARS_CMD_ADD_RESULT:  m_a = m_a ^ (i_adder_a + m_a + i_subtract);
            ARS_CMD_INTERCHANGE: {m_a, m_e} = {m_e, m_a};
            ARS_CMD_COPY_TO_EXT: m_e = m_a;
            ARS_CMD_SHR1:        {m_a, m_e} = p >> 1;
            ARS_CMD_SHL1:        {m_a, m_e} = p << 1;
            ARS_CMD_SHR4:        {m_a, m_e} = em ? {p[3:0], p[63:36],
                                 p[31:28], p[31:4]} : {p[3:0], p[63:4]};
            ARS_CMD_SHL4:        {m_a, m_e} = p << 4;
            default:             m_a = m_a;
        endcase
    endtask
    // Every port field except carry clear against the model
    task automatic check();
        `CHK(o_acc, m_a)
        `CHK(o_ext, m_e)
        `CHK(o_acc_zero, m_a == 32'h0000_0000)
        `CHK(o_fanout.cond_code, m_a[29:28])
        `CHK(o_fanout.prog_mask, m_a[27:24])
        `CHK(o_fanout.prog_mask_zero, m_a[27:24] == 4'h0)
        `CHK(o_fanout.sys_mask, m_a[31:24])
        `CHK(o_fanout.machine_state, m_a[19:16])
        `CHK({o_fanout.chan_decode, o_fanout.chan_addr}, m_a[10:0])
        `CHK(o_fanout.shift_count, m_a[5:0])
        `CHK(o_fanout.shift_ovf_bits, m_a[31:30])
        `CHK(o_fanout.sign, m_a[31])
        `CHK(o_addr, {6'h00, |m_a[23:17], m_a[16:0], m_a[0]})
        `CHK(o_fanout.ext_parallel, m_p)
        `CHK(o_store_data, m_s)
    endtask
    // One command with an idle cycle behind it, then judged
    task automatic run(input ars_cmd_e c, input logic [31:0] d,
                       input logic dc = 1'b0, input logic em = 1'b0);
        seq.issue(c, d, dc, em);
        // Store path shows the value from before this command
        m_s = {m_a[31] ^ i_sign_invert, m_a[30:0]};
        mdl(c, d, dc, em);
        seq.idle();
        #1;
        check();
    endtask
    // Set then entry back to back gives the complement
    task automatic t_cpl();
        run(ARS_CMD_RESET_ALL, 32'h0000_0000);
        seq.issue(ARS_CMD_SET_ONES, 32'h0000_0000, 1'b0, 1'b0);
        mdl(ARS_CMD_SET_ONES, 32'h0000_0000, 1'b0, 1'b0);
        run(ARS_CMD_ENTRY, 32'h0000_0037);
        run(ARS_CMD_ENTRY, 32'h1234_5678, 1'b1);
        run(ARS_CMD_ENTRY, 32'hA5A5_0F0F);
    endtask
    // Byte clear keeps the low part; full clear pulses carry clear
    task automatic t_clear();
        run(ARS_CMD_SET_ONES, 32'h0000_0000);
        run(ARS_CMD_RESET_BYTE0, 32'h0000_0000);
        run(ARS_CMD_RESET_ALL, 32'h0000_0000);
        `CHK(o_carry_clear, 1'b1)
    endtask
    // Swap, copy, and all shift kinds on a busy pair
    task automatic t_move();
        run(ARS_CMD_ENTRY, 32'h89AB_CDEF);
        run(ARS_CMD_INTERCHANGE, 32'h0000_0000);
        run(ARS_CMD_ENTRY, 32'hC3C3_5A5A);
        run(ARS_CMD_COPY_TO_EXT, 32'h0000_0000);
        run(ARS_CMD_ENTRY, 32'h0F1E_2D3C);
        run(ARS_CMD_SHR1, 32'h0000_0000);
        run(ARS_CMD_SHL1, 32'h0000_0000);
        run(ARS_CMD_SHR4, 32'h0000_0000);
        run(ARS_CMD_SHR4, 32'h0000_0000, 1'b0, 1'b1);
        run(ARS_CMD_SHL4, 32'h0000_0000);
        run(ARS_CMD_INTERCHANGE, 32'h0000_0000);
    endtask
    // Add and subtract results, with the sign path inverted
    task automatic t_add();
        run(ARS_CMD_RESET_ALL, 32'h0000_0000);
        run(ARS_CMD_ENTRY, 32'h0000_0039);
        @(posedge i_clock) i_adder_a <= 32'h0000_0015;
        run(ARS_CMD_ADD_RESULT, 32'h0000_0000);
        @(posedge i_clock) i_subtract <= 1'b1;
        i_sign_invert <= 1'b1;
        run(ARS_CMD_ADD_RESULT, 32'h0000_0000);
        @(posedge i_clock) i_clk_en <= 1'b0;
        seq.issue(ARS_CMD_SET_ONES, 32'h0000_0000, 1'b0, 1'b0);
        seq.idle();
        #1;
        `CHK(o_acc, m_a)
        @(posedge i_clock) i_clk_en <= 1'b1;
        i_sign_invert <= 1'b0;
    endtask
    // Mid-run reset returns every output to its idle value
    task automatic t_rst();
        run(ARS_CMD_SET_ONES, 32'h0000_0000);
        @(posedge i_clock) i_rst_n <= 1'b0;
        @(posedge i_clock) i_rst_n <= 1'b1;
        {m_a, m_e, m_p, m_s} = '0;
        seq.idle();
        #1;
        check();
        `CHK(o_carry_clear, 1'b0)
    endtask
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // Cycle ceiling well above the roughly 60 cycles the run needs
    initial
    begin
        cycles = 0;
        forever @(posedge i_clock)
        begin
            cycles++;
            if (cycles == 5000)
            begin
                n_mismatch++;
                complete_run();
            end
        end
    end
    initial
    begin
        {i_rst_n, i_subtract, i_sign_invert, i_clk_en} = 4'h1;
        {i_adder_a, m_a, m_e, m_p, m_s, n_mismatch, n_compared} = '0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        seq.idle();
        #1;
        check();
        `CHK(o_carry_clear, 1'b0)
        t_cpl();
        t_clear();
        t_move();
        t_rst();
        t_add();
        complete_run();
    end
endmodule
bind ars_accumulator ars_monitor #(.W(W)) u_mon (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_cmd(i_cmd),
    .i_funnel(i_funnel), .i_decondition(i_decondition),
    .i_exp_match(i_exp_match), .i_sign_invert(i_sign_invert),
    .o_acc(o_acc), .o_ext(o_ext), .o_carry_clear(o_carry_clear),
    .o_acc_zero(o_acc_zero), .o_store_data(o_store_data));

// file: verilog/ars_accumulator.sv
// Accumulator register with extension register, shifter and fan-out.
// Assumes one clock domain; the sequencer issues one command per cycle
// and keeps operand funnel data stable while entry is applied.
`timescale 1ns/1ps

// Overview of operation
// - 32-bit register, funnel data XORed in
// - All-zero detector on whole register
// - Reset clears all with carry, or byte0
// - Set forces ones for complementing
// - Entry enabled unless deconditioned
// - Interchange swaps accumulator and extension
// - Second status load copies, keeps accumulator
// - Shift one moves coupled 64-bit pair
// - Shift four moves coupled 64-bit pair
// - Right four wraps extension low into top
// - Exponent match breaks accumulator-extension link
// - Bits 2-3 condition code, 4-7 mask
// - Bits 4-7 zero check for overflow
// - Bits 08-31 feed address, 08-14 compressed
// - Bits 12-15 load machine-state latches
// - Bits 21-23 decode, 24-31 channel address
// - Bits 26-31 load shift counter
// - Bits 00-01 to shift overflow detect
// - Bit 00 is sign for conditions
// - Bit 00 true or inverted to storage
// - Bits 30-31 copied to parallel positions
// - Bits 00-07 for mask test, system mask
// - Subtract forces adder carry-in
// - Result is adder output XORed in
module ars_accumulator
    import ars_pkg::*;
#(
    parameter int unsigned W = ARS_W
)
(
    input  wire logic          i_clock,
    input  wire logic          i_rst_n,
    input  wire logic          i_clk_en,
    input  wire ars_cmd_e      i_cmd,
    input  wire logic [W-1:0]  i_funnel,
    input  wire logic          i_decondition,
    input  wire logic          i_exp_match,
    input  wire logic [W-1:0]  i_adder_a,
    input  wire logic          i_subtract,
    input  wire logic          i_sign_invert,
    output logic [W-1:0]       o_acc,
    output logic [W-1:0]       o_ext,
    output logic               o_carry_clear,
    output logic               o_acc_zero,
    output logic [W-1:0]       o_store_data,
    output ars_fanout_s        o_fanout,
    output ars_addr_s          o_addr
);
    // Index helper: bit "nn" in the documented numbering (00 = MSB)
    function automatic int unsigned pos(input int unsigned n);
        pos = W - 1 - n;
    endfunction

    logic [W-1:0]   acc_q;
    logic [W-1:0]   acc_d;
    logic [W-1:0]   ext_q;
    logic [W-1:0]   ext_d;
    logic [1:0]     par_q;
    logic [1:0]     par_d;
    logic           carry_clr_q;
    logic [W-1:0]   sum;
    logic [W-1:0]   store_fix;
    logic [2*W-1:0] pair;
    logic [2*W-1:0] pair_sh;

    assign pair = {acc_q, ext_q};

    ars_adder #(
        .W (W)
    ) u_adder (
        .i_a           (i_adder_a),
        .i_c           (acc_q),
        .i_force_carry (i_subtract),
        .o_sum         (sum)
    );

    ars_sign_fix #(
        .W (W)
    ) u_sign (
        .i_data   (acc_q),
        .i_invert (i_sign_invert),
        .o_data   (store_fix)
    );

    // Next-state for the coupled pair; one command only per cycle.
    // A single encoded code is what keeps entry and shifts apart:
    // two strobes at once would need a priority the hardware lacks.
    always_comb
    begin
        acc_d   = acc_q;
        ext_d   = ext_q;
        par_d   = par_q;
        pair_sh = pair;
        unique case (i_cmd)
            ARS_CMD_NONE:
            begin
                acc_d = acc_q;
            end
            ARS_CMD_RESET_ALL:
            begin
                acc_d = ARS_ZERO;
            end
            ARS_CMD_RESET_BYTE0:
            begin
                acc_d = acc_q & ARS_BYTE0_KEEP;
            end
            ARS_CMD_SET_ONES:
            begin
                acc_d = ARS_ONES;
            end
            ARS_CMD_ENTRY:
            begin
                if (!i_decondition)
                begin
                    acc_d = acc_q ^ i_funnel;
                end
            end
            ARS_CMD_ADD_RESULT:
            begin
                acc_d = acc_q ^ sum;
            end
            ARS_CMD_INTERCHANGE:
            begin
                acc_d = ext_q;
                ext_d = acc_q;
            end
            ARS_CMD_COPY_TO_EXT:
            begin
                ext_d = acc_q;
            end
            ARS_CMD_SHR1:
            begin
                pair_sh = {1'b0, pair[2*W-1:1]};
                acc_d   = pair_sh[2*W-1:W];
                ext_d   = pair_sh[W-1:0];
                par_d   = {acc_q[pos(ARS_PAR_HI) + 1], par_q[1]};
            end
            ARS_CMD_SHL1:
            begin
                pair_sh = {pair[2*W-2:0], 1'b0};
                acc_d   = pair_sh[2*W-1:W];
                ext_d   = pair_sh[W-1:0];
            end
            ARS_CMD_SHR4:
            begin
                // loop extension low digit to top
                pair_sh = {pair[ARS_DIGIT-1:0], pair[2*W-1:ARS_DIGIT]};
                acc_d   = pair_sh[2*W-1:W];
                ext_d   = pair_sh[W-1:0];
                if (i_exp_match)
                begin
                    ext_d = {ext_q[W-1:W-ARS_DIGIT],
                             ext_q[W-1:ARS_DIGIT]};
                    ext_d[W-1:W-ARS_DIGIT] = ext_q[W-1:W-ARS_DIGIT];
                end
                par_d   = acc_q[pos(ARS_PAR_HI)+1 +: 2];
            end
            ARS_CMD_SHL4:
            begin
                pair_sh = {pair[2*W-ARS_DIGIT-1:0], {ARS_DIGIT{1'b0}}};
                acc_d   = pair_sh[2*W-1:W];
                ext_d   = pair_sh[W-1:0];
            end
            default:
            begin
                acc_d = acc_q;
            end
        endcase
        // parallel copy on transfers into extension
        if (i_cmd == ARS_CMD_INTERCHANGE || i_cmd == ARS_CMD_COPY_TO_EXT)
        begin
            par_d = acc_q[pos(ARS_PAR_LO) +: 2];
        end
    end

    // Accumulator state; one command is applied per enabled edge
    // and a low enable freezes it along with every other flop
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            acc_q <= ARS_ZERO;
        end
        else if (i_clk_en)
        begin
            acc_q <= acc_d;
        end
    end

    // Extension register, coupled to the right of the accumulator;
    // it only changes on interchange, copy and the shift commands
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            ext_q <= ARS_ZERO;
        end
        else if (i_clk_en)
        begin
            ext_q <= ext_d;
        end
    end

    // Parallel positions; they track the low bits only on loads and
    // right shifts, so they may differ from the extension's own bits
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            par_q <= 2'h0;
        end
        else if (i_clk_en)
        begin
            par_q <= par_d;
        end
    end

    // Companion carry register clear strobe, with the full reset only
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            carry_clr_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            carry_clr_q <= (i_cmd == ARS_CMD_RESET_ALL);
        end
    end

    // Zero flag is formed from the next value so it lines up with
    // o_acc; a flag taken from acc_q would trail by one cycle
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_acc_zero <= 1'b1;
        end
        else if (i_clk_en)
        begin
            o_acc_zero <= (acc_d == ARS_ZERO);
        end
    end

    // Store path lags the register by one cycle: it is taken from
    // the settled register, so the invert request must stand then
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_store_data <= ARS_ZERO;
        end
        else if (i_clk_en)
        begin
            o_store_data <= store_fix;
        end
    end

    // Status, channel and shift fan-out; fields of the new value, so
    // consumers see them in the same cycle as the register itself
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_fanout <= '0;
        end
        else if (i_clk_en)
        begin
            o_fanout.cond_code <= acc_d[pos(ARS_CC_LO) +: 2];
            o_fanout.prog_mask <= acc_d[pos(ARS_PM_LO) +: 4];
            o_fanout.prog_mask_zero <= (acc_d[pos(ARS_PM_LO) +: 4] == 4'h0);
            o_fanout.sys_mask <= acc_d[W-1 -: ARS_BYTE_W];
            o_fanout.machine_state <= acc_d[pos(ARS_MS_LO) +: 4];
            o_fanout.chan_decode <= acc_d[pos(ARS_CHD_LO) +: 3];
            o_fanout.chan_addr   <= acc_d[pos(ARS_CHA_LO) +: 8];
            o_fanout.shift_count <= acc_d[pos(ARS_SC_LO) +: 6];
            o_fanout.shift_ovf_bits <= {acc_d[pos(ARS_SIGN)],
                                        acc_d[pos(ARS_OVF_B)]};
            o_fanout.sign <= acc_d[pos(ARS_SIGN)];
            o_fanout.ext_parallel <= par_d;
        end
    end

    // Address feed; the upper field folds to one flag bit, so a
    // nonzero upper part can never alias a low address
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            o_addr <= '0;
        end
        else if (i_clk_en)
        begin
            // address feed, 08-14 merged to 14
            o_addr.addr <= {
                {(ARS_SAR_CMP-ARS_SAR_HI){1'b0}},
                |acc_d[pos(ARS_SAR_CMP) +: (ARS_SAR_CMP-ARS_SAR_HI+1)],
                acc_d[pos(ARS_SAR_LO) +: (ARS_SAR_LO-ARS_SAR_CMP)]};
            o_addr.even_odd <= acc_d[pos(ARS_SAR_LO)];
        end
    end

    // Register views come straight from the state flops; the fan-out
    // above is registered on its own so that no output is a gate
    // away from a flop, at the cost of a second copy of each field
    assign o_acc         = acc_q;
    assign o_ext         = ext_q;
    assign o_carry_clear = carry_clr_q;
endmodule

// file: verilog/ars_adder.sv
// Carry-lookahead adder stage feeding the accumulator.
// Assumes operands are stable in the cycle the result is used.
`timescale 1ns/1ps
module ars_adder
    import ars_pkg::*;
#(
    parameter int unsigned W = ARS_W
)
(
    input  wire logic [W-1:0] i_a,
    input  wire logic [W-1:0] i_c,
    input  wire logic         i_force_carry,
    output logic      [W-1:0] o_sum
);
    logic [W:0] full;

    // Forced carry gives two's complement of a ones-complemented operand
    assign full  = {1'b0, i_a} + {1'b0, i_c} + {{W{1'b0}}, i_force_carry};
    assign o_sum = full[W-1:0];
endmodule

// file: verilog/ars_sign_fix.sv
// Sign-correction gating on the path towards the storage data register.
// Assumes the invert request comes from the control sequencer.
`timescale 1ns/1ps
module ars_sign_fix
    import ars_pkg::*;
#(
    parameter int unsigned W = ARS_W
)
(
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_invert,
    output logic      [W-1:0] o_data
);
    // Only the sign position (MSB, bit 00) is touched
    assign o_data = {i_data[W-1] ^ i_invert, i_data[W-2:0]};
endmodule
